// *** logic/vpsc_defs.vh ***
// Offsets, field positions and reset values of the emulated PHY special control/status register
`ifndef VPSC_DEFS_VH
`define VPSC_DEFS_VH
`define VPSC_REG_OFFSET     12'h01dc
`define VPSC_REG_INDEX      5'h1f
`define VPSC_BIT_MODE2      15
`define VPSC_BIT_LOOPBACK   14
`define VPSC_BIT_MODE1      9
`define VPSC_BIT_MODE0      8
`define VPSC_BIT_COLTEST    7
`define VPSC_BIT_CLKDIR     6
`define VPSC_BIT_CLKSTR     5
`define VPSC_LOOPBACK_RST   1'h0
`define VPSC_COLTEST_RST    1'h0
`define VPSC_MODE_RMII_MAC  3'h2
`define VPSC_MODE_RMII_PHY  3'h3
`define VPSC_STRAP_LOAD_CNT 2'h2
`define VPSC_STRAP_DONE_CNT 2'h3
`endif

// *** logic/vpsc_sync2.v ***
// Two-flop synchroniser for a pin level
module vpsc_sync2 (
	input  wire core_clk,
	input  wire rst_n,
	input  wire pinIn,
	output reg  syncOut
);
	reg stage1;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			stage1  <= pinIn;
			syncOut <= stage1;
		end
	end
endmodule // vpsc_sync2

// *** logic/vpsc_special_ctl.v ***
// Emulated PHY special control/status register with loopback, collision test and refclk controls
// What this block does
// - Loopback bit set: port MAC transmissions return to switch engine, not MII.
// - Loopback keeps working while the emulated PHY isolate bit is set.
// - Read-only mode code: bit 15 high, bits 9:8 low; 010 MAC, 011 PHY.
// - Collision test set: collision asserted whenever switch engine transmits.
// - Clock direction bit: 0 refclk pin input, 1 refclk pin driven output.
// - Clock strength bit: clear selects lower drive, set selects higher drive.
// - 32-bit word with zero upper half; 16-bit over management interface.
// - Mode, clock direction and strength reset from straps sampled at reset.
// - Clock bits reset by device emulated PHY reset, kept on soft reset.
`include "vpsc_defs.vh"
module vpsc_special_ctl (
	input  wire        core_clk,
	input  wire        rst_n,
	// System register space, word access
	input  wire        sysWrEn,
	input  wire        sysRdEn,
	input  wire [11:0] sysAddr,
	input  wire [31:0] sysWrData,
	output reg  [31:0] sysRdData,
	output reg         sysRdValid,
	// MII management access, register index
	input  wire        mgmtWrEn,
	input  wire        mgmtRdEn,
	input  wire [4:0]  mgmtRegIdx,
	input  wire [15:0] mgmtWrData,
	output reg  [15:0] mgmtRdData,
	output reg         mgmtRdValid,
	// Resets of the emulated PHY
	input  wire        phyResetReq,
	input  wire        phySoftReset,
	// Straps (pins)
	input  wire [2:0]  modeStrap,
	input  wire        clkDirStrap,
	input  wire        clkStrStrap,
	// Port datapath
	input  wire        isolateBit,
	input  wire        macTxEn,
	input  wire [1:0]  macTxData,
	input  wire        sweTxActive,
	output reg         miiTxEn,
	output reg  [1:0]  miiTxData,
	output reg         loopRxDv,
	output reg  [1:0]  loopRxData,
	output reg         fabricCol,
	// Reference clock pad controls
	output reg         refClkOe,
	output reg         refClkHighDrive
);
	wire [2:0] modeSync;
	wire       dirSync;
	wire       strSync;
	genvar     g;

	generate
		for (g = 0; g < 3; g = g + 1) begin : gModeSync
			vpsc_sync2 uModeSync (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.pinIn    (modeStrap[g]),
				.syncOut  (modeSync[g])
			);
		end
	endgenerate
	vpsc_sync2 uDirSync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pinIn    (clkDirStrap),
		.syncOut  (dirSync)
	);
	vpsc_sync2 uStrSync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pinIn    (clkStrStrap),
		.syncOut  (strSync)
	);

	reg  [2:0] modeCode;
	reg        loopback;
	reg        colTest;
	reg        clkDir;
	reg        clkStr;
	reg  [1:0] strapCnt;
	reg  [2:0] next_modeCode;
	reg        next_loopback;
	reg        next_colTest;
	reg        next_clkDir;
	reg        next_clkStr;
	wire       strapLoad = (strapCnt == `VPSC_STRAP_LOAD_CNT);
	wire       strapDone = (strapCnt == `VPSC_STRAP_DONE_CNT);

	wire sysHit  = (sysAddr == `VPSC_REG_OFFSET);
	wire mgmtHit = (mgmtRegIdx == `VPSC_REG_INDEX);
	wire wrSys   = sysWrEn && sysHit;
	wire wrMgmt  = mgmtWrEn && mgmtHit;
	wire [15:0] wrWord = wrSys ? sysWrData[15:0] : mgmtWrData;

	wire [15:0] regWord = {modeCode[2], loopback, 4'h0, modeCode[1:0],
		colTest, clkDir, clkStr, 5'h00};

	// Straps settle through the synchronisers; one capture two cycles after release
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strapCnt <= 2'h0;
		end else if (!strapDone) begin
			strapCnt <= strapCnt + 2'h1;
		end
	end

	// Device reset and strap capture win over writes; mode code is never written
	always @* begin
		next_modeCode = modeCode;
		next_loopback = loopback;
		next_colTest  = colTest;
		next_clkDir   = clkDir;
		next_clkStr   = clkStr;
		if (strapLoad || phyResetReq) begin
			next_modeCode = modeSync;
			next_clkDir   = dirSync;
			next_clkStr   = strSync;
		end else if (wrSys || wrMgmt) begin
			next_clkDir = wrWord[`VPSC_BIT_CLKDIR];
			next_clkStr = wrWord[`VPSC_BIT_CLKSTR];
		end
		if (phyResetReq || phySoftReset) begin
			next_loopback = `VPSC_LOOPBACK_RST;
			next_colTest  = `VPSC_COLTEST_RST;
		end else if (wrSys || wrMgmt) begin
			next_loopback = wrWord[`VPSC_BIT_LOOPBACK];
			next_colTest  = wrWord[`VPSC_BIT_COLTEST];
		end
	end

	// Mode code reads zero until the straps are captured
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			modeCode <= 3'h0;
			clkDir   <= 1'b0;
			clkStr   <= 1'b0;
		end else begin
			modeCode <= next_modeCode;
			clkDir   <= next_clkDir;
			clkStr   <= next_clkStr;
		end
	end

	// Soft reset clears only the plain control bits; clock bits hold
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loopback <= `VPSC_LOOPBACK_RST;
			colTest  <= `VPSC_COLTEST_RST;
		end else begin
			loopback <= next_loopback;
			colTest  <= next_colTest;
		end
	end

	// System word zero-padded above bit 15; misses still answer
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysRdData  <= 32'h0000_0000;
			sysRdValid <= 1'b0;
		end else begin
			sysRdValid <= sysRdEn;
			sysRdData  <= (sysRdEn && sysHit) ? {16'h0000, regWord} : 32'h0000_0000;
		end
	end

	// Management view is the bare 16-bit register
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mgmtRdData  <= 16'h0000;
			mgmtRdValid <= 1'b0;
		end else begin
			mgmtRdValid <= mgmtRdEn;
			mgmtRdData  <= (mgmtRdEn && mgmtHit) ? regWord : 16'h0000;
		end
	end

	// Isolate blocks only the external path, never the loopback
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			miiTxEn   <= 1'b0;
			miiTxData <= 2'h0;
		end else begin
			miiTxEn   <= macTxEn && !loopback && !isolateBit;
			miiTxData <= (loopback || isolateBit) ? 2'h0 : macTxData;
		end
	end

	// Far loopback back into the switch engine
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loopRxDv   <= 1'b0;
			loopRxData <= 2'h0;
		end else begin
			loopRxDv   <= macTxEn && loopback;
			loopRxData <= loopback ? macTxData : 2'h0;
		end
	end

	// Forced collision lasts exactly as long as the engine transmits
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fabricCol <= 1'b0;
		end else begin
			fabricCol <= colTest && sweTxActive;
		end
	end

	// Pad controls lag the register by one cycle
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			refClkOe        <= 1'b0;
			refClkHighDrive <= 1'b0;
		end else begin
			refClkOe        <= clkDir;
			refClkHighDrive <= clkStr;
		end
	end
endmodule // vpsc_special_ctl

// *** bench/vpsc_special_ctl_monitor.sv ***
// Port checker for the special control/status register
module vpsc_special_ctl_monitor (
	input logic        core_clk,
	input logic        rst_n,
	input logic        sysRdEn,
	input logic [11:0] sysAddr,
	input logic [31:0] sysRdData,
	input logic        sysRdValid,
	input logic        mgmtRdEn,
	input logic        mgmtRdValid,
	input logic        macTxEn,
	input logic        sweTxActive,
	input logic        miiTxEn,
	input logic        loopRxDv,
	input logic        fabricCol
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (sysRdEn |=> sysRdValid) else $error("no read answer");
	rd_cause_a: assert property (sysRdValid |-> $past(sysRdEn)) else $error("stray read answer");
	pad_zero_a: assert property (sysRdValid |-> sysRdData[31:16] == 16'h0000) else $error("pad set");
	miss_zero_a: assert property (sysRdValid && $past(sysAddr) != 12'h01dc |-> sysRdData == 32'h0000_0000)
		else $error("miss not zero");
	mgmt_answer_a: assert property (mgmtRdEn |=> mgmtRdValid) else $error("no mgmt answer");
	loop_block_a: assert property (loopRxDv |-> !miiTxEn) else $error("looped frame on mii");
	loop_cause_a: assert property (loopRxDv |-> $past(macTxEn)) else $error("loop without tx");
	col_cause_a: assert property (fabricCol |-> $past(sweTxActive)) else $error("col without tx");
endmodule // vpsc_special_ctl_monitor

bind vpsc_special_ctl vpsc_special_ctl_monitor mon (.*);

// *** bench/vpsc_special_ctl_tb_top.sv ***
// Testbench for the special control/status register
module vpsc_special_ctl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk, rst_n, sysWrEn, sysRdEn, sysRdValid, mgmtWrEn, mgmtRdEn, mgmtRdValid, phyResetReq;
	logic        phySoftReset, clkDirStrap, clkStrStrap, isolateBit, macTxEn, sweTxActive, miiTxEn, loopRxDv;
	logic        fabricCol, refClkOe, refClkHighDrive;
	logic [11:0] sysAddr;
	logic [31:0] sysWrData, sysRdData;
	logic [4:0]  mgmtRegIdx;
	logic [15:0] mgmtWrData, mgmtRdData;
	logic [2:0]  modeStrap;
	logic [1:0]  macTxData, miiTxData, loopRxData;
	int          n_fail = 0, check_count = 0, cyc = 0;
	vpsc_special_ctl dut (.*);
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	// Run needs about 55 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, exp);
		chk32({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#10;
	endtask
	task automatic sysRead(input logic [11:0] a, input logic [31:0] e);
		step(1);
		sysRdEn = 1;
		sysAddr = a;
		step(1);
		sysRdEn = 0;
		chk1(sysRdValid, 1'h1);
		chk32(sysRdData, e);
	endtask
	initial begin
		{sysWrEn, sysRdEn, mgmtWrEn, mgmtRdEn, phyResetReq, phySoftReset, isolateBit, macTxEn, sweTxActive} = '0;
		{sysAddr, sysWrData, mgmtRegIdx, mgmtWrData, macTxData} = '0;
		{modeStrap, clkDirStrap, clkStrStrap, rst_n} = 6'h1c;
		repeat (10) @(posedge core_clk);
		#10 rst_n = 1;
		step(10);
		sysRead(12'h01dc, 32'h0000_0340);
		chk1(refClkOe, 1'h1);
		chk1(refClkHighDrive, 1'h0);
		$display("strap test done");
		sysWrEn = 1;
		sysAddr = 12'h01dc;
		sysWrData = 32'h0000_c0a0;
		step(1);
		sysWrEn = 0;
		sysRead(12'h01dc, 32'h0000_43a0);
		step(2);
		chk1(refClkOe, 1'h0);
		chk1(refClkHighDrive, 1'h1);
		sysRead(12'h01e0, 32'h0000_0000);
		mgmtRdEn = 1;
		mgmtRegIdx = 5'h1f;
		step(1);
		mgmtRdEn = 0;
		chk1(mgmtRdValid, 1'h1);
		chk32({16'h0000, mgmtRdData}, 32'h0000_43a0);
		$display("access test done");
		{isolateBit, macTxEn, macTxData, sweTxActive} = 5'h1d;
		step(2);
		chk1(loopRxDv, 1'h1);
		chk32({30'h0000_0000, loopRxData}, 32'h0000_0002);
		chk1(miiTxEn, 1'h0);
		chk1(fabricCol, 1'h1);
		{isolateBit, macTxEn, sweTxActive} = '0;
		$display("loopback test done");
		phySoftReset = 1;
		step(1);
		phySoftReset = 0;
		sysRead(12'h01dc, 32'h0000_0320);
		{isolateBit, macTxEn, macTxData, sweTxActive} = 5'h0b;
		step(2);
		chk1(miiTxEn, 1'h1);
		chk32({30'h0000_0000, miiTxData}, 32'h0000_0001);
		chk1(loopRxDv, 1'h0);
		chk1(fabricCol, 1'h0);
		{isolateBit, macTxEn, macTxData, sweTxActive} = '0;
		modeStrap = 3'h2;
		step(2);
		phyResetReq = 1;
		step(1);
		phyResetReq = 0;
		step(8);
		sysRead(12'h01dc, 32'h0000_0240);
		chk1(refClkOe, 1'h1);
		chk1(refClkHighDrive, 1'h0);
		$display("reset test done");
		mgmtWrEn = 1;
		mgmtRegIdx = 5'h1e;
		mgmtWrData = 16'h4080;
		step(1);
		mgmtRegIdx = 5'h1f;
		mgmtWrData = 16'h0020;
		step(1);
		mgmtWrEn = 0;
		sysRead(12'h01dc, 32'h0000_0220);
		chk1(refClkOe, 1'h0);
		chk1(refClkHighDrive, 1'h1);
		mgmtRdEn = 1;
		mgmtRegIdx = 5'h1e;
		step(1);
		mgmtRdEn = 0;
		chk1(mgmtRdValid, 1'h1);
		chk32({16'h0000, mgmtRdData}, 32'h0000_0000);
		$display("mgmt write test done");
		end_sim();
	end
endmodule // vpsc_special_ctl_tb_top
